// [qrp_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module qrp_fifo #(
	parameter int W = 32,
	parameter int D = 4
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW:0] wp;
		logic [AW:0] rp;
	} qrp_fifo_s;

	qrp_fifo_s q, n;
	logic full, empty;

	assign empty = (q.wp == q.rp);
	assign full = (q.wp[AW-1:0] == q.rp[AW-1:0]) && (q.wp[AW] != q.rp[AW]);

	always_comb begin
		n = q;
		if (in_valid_i && !full) begin
			n.mem[q.wp[AW-1:0]] = in_data_i;
			n.wp = q.wp + 1'b1;
		end
		if (out_ready_i && !empty) begin
			n.rp = q.rp + 1'b1;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = q.mem[q.rp[AW-1:0]];
endmodule : qrp_fifo
`default_nettype wire

// [qrp_flash_seq.sv]
`timescale 1ns/10ps
`default_nettype none
module qrp_flash_seq
	import qrp_pkg::*;
(
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic sck_i,
	input wire logic chip_en_n_i,
	input wire logic [3:0] line_i,
	output logic [3:0] line_o,
	output logic [3:0] line_oe_o,
	input wire logic qpi_mode_i,
	input wire logic [3:0] protect_bits_i,
	output logic [QRP_ADDR_W-1:0] mem_addr_o,
	input wire logic [7:0] mem_rdata_i,
	output logic prog_valid_o,
	input wire logic prog_ready_i,
	output logic [QRP_ADDR_W-1:0] prog_addr_o,
	output logic [7:0] prog_data_o,
	output logic write_in_progress_o,
	output logic write_enable_latch_o,
	output logic continuous_read_mode_o
);
	typedef struct packed {
		qrp_link_e st;
		qrp_prog_e pst;
		logic [5:0] cnt;
		logic [7:0] sh;
		logic [QRP_ADDR_W-1:0] addr;
		logic [7:0] col;
		logic [7:0] idx;
		logic [7:0] dbyte;
		logic [1:0] rd_pend;
		logic half;
		logic [3:0] io_out;
		logic [3:0] io_oe;
		logic [QRP_ADDR_W-1:0] mem_addr;
		logic sck_prev;
		logic cs_prev;
		logic write_in_progress;
		logic write_enable_latch;
		logic cr;
		logic [QRP_PAGE_BYTES-1:0] vld;
		logic [QRP_PAGE_BYTES*8-1:0] pbuf;
	} qrp_state_s;

	qrp_state_s q, n;

	logic [5:0] pins_s;
	logic sck_s, cs_s;
	logic [3:0] io_s;
	logic rise, fall, cs_up;
	logic [7:0] sh_in;
	logic [QRP_ADDR_W-1:0] addr_quad, addr_in;
	logic [5:0] byte_last, addr_last;
	logic [7:0] stat_now;
	logic prot;
	logic write_enable_cmd_hit;
	logic f_in_valid, f_in_ready, f_out_valid;
	logic [QRP_FIFO_W-1:0] f_in_data, f_out_data;

	// Link pins come from the host's clock, two flops before any use
	qrp_sync #(
		.W(6),
		.RST(6'h02)
	) u_sync (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.d_i({line_i, chip_en_n_i, sck_i}),
		.q_o(pins_s)
	);

	assign sck_s = pins_s[0];
	assign cs_s = pins_s[1];
	assign io_s = pins_s[5:2];
	assign rise = sck_s && !q.sck_prev;
	assign fall = !sck_s && q.sck_prev;
	assign cs_up = cs_s && !q.cs_prev;

	assign sh_in = qpi_mode_i ? {q.sh[3:0], io_s} : {q.sh[6:0], io_s[0]};
	assign addr_quad = {q.addr[QRP_ADDR_W-5:0], io_s};
	assign addr_in = qpi_mode_i ? addr_quad : {q.addr[QRP_ADDR_W-2:0], io_s[0]};
	assign byte_last = qpi_mode_i ? (QRP_BYTE_NIBS - 6'h01) : (QRP_BYTE_BITS - 6'h01);
	assign addr_last = qpi_mode_i ? (QRP_ADDR_NIBS - 6'h01) : (QRP_ADDR_BITS - 6'h01);

	always_comb begin
		stat_now = 8'h00;
		stat_now[QRP_WIP_BIT] = q.write_in_progress;
		stat_now[QRP_WEL_BIT] = q.write_enable_latch;
	end

	// Top regions are protected; the count of regions is the protect field
	assign prot = (protect_bits_i != 4'h0)
		&& (({1'b0, q.addr[QRP_ADDR_W-1:QRP_ADDR_W-4]} + {1'b0, protect_bits_i}) >= QRP_PROT_REGIONS);

	assign f_in_valid = (q.pst == PG_PUSH);
	assign f_in_data = {q.addr[QRP_ADDR_W-1:8], q.idx, mem_rdata_i & q.pbuf[{q.idx, 3'h0} +: 8]};

	qrp_fifo #(
		.W(QRP_FIFO_W),
		.D(QRP_FIFO_DEPTH)
	) u_fifo (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.in_valid_i(f_in_valid),
		.in_ready_o(f_in_ready),
		.in_data_i(f_in_data),
		.out_valid_o(f_out_valid),
		.out_ready_i(prog_ready_i),
		.out_data_o(f_out_data)
	);

	always_comb begin
		n = q;
		write_enable_cmd_hit = 1'b0;
		n.sck_prev = sck_s;
		n.cs_prev = cs_s;
		// Array answers a cycle after the address, so data is taken one cycle later
		n.rd_pend = {q.rd_pend[0], 1'b0};
		if (q.rd_pend[1]) begin
			n.dbyte = mem_rdata_i;
		end
		if (cs_s) begin
			n.st = LK_IDLE;
			n.io_oe = 4'h0;
			n.cnt = 6'h00;
			if (cs_up && q.st == LK_PDATA && q.cnt == 6'h00 && (|q.vld)
				&& !prot && !q.write_in_progress && q.write_enable_latch) begin
				n.write_in_progress = 1'b1;
				n.pst = PG_LOOK;
				n.idx = 8'h00;
			end
		end else begin
			case (q.st)
				LK_IDLE: begin
					// Opcode skipped while continuous read is armed
					n.st = q.cr ? LK_ADDR : LK_CMD;
					n.cnt = 6'h00;
				end
				LK_CMD: begin
					if (rise) begin
						n.sh = sh_in;
						n.cnt = q.cnt + 6'h01;
						if (q.cnt == byte_last) begin
							n.cnt = 6'h00;
							case (sh_in)
								QRP_OP_QREAD: begin
									n.st = q.write_in_progress ? LK_SKIP : LK_ADDR;
								end
								QRP_OP_PROG: begin
									// A program in flight keeps its page buffer
									n.st = q.write_in_progress ? LK_SKIP : LK_PADDR;
									n.vld = q.write_in_progress ? q.vld : '0;
								end
								QRP_OP_WRITE_ENABLE_CMD: begin
									n.write_enable_latch = 1'b1;
									write_enable_cmd_hit = 1'b1;
									n.st = LK_SKIP;
								end
								QRP_OP_STATUS_READ_CMD: begin
									n.st = LK_STAT;
									n.half = 1'b0;
								end
								default: begin
									n.st = LK_SKIP;
								end
							endcase
						end
					end
				end
				LK_ADDR: begin
					if (rise) begin
						n.addr = addr_quad;
						n.cnt = q.cnt + 6'h01;
						if (q.cnt == QRP_ADDR_NIBS - 6'h01) begin
							n.st = LK_DUMMY;
							n.cnt = 6'h00;
							n.mem_addr = addr_quad;
							n.rd_pend = 2'h1;
						end
					end
				end
				LK_DUMMY: begin
					if (rise) begin
						n.cnt = q.cnt + 6'h01;
						if (q.cnt == 6'h00) begin
							n.cr = (io_s == QRP_CONT_NIB);
						end
						if (q.cnt == QRP_DUMMY_CYC - 6'h01) begin
							n.st = LK_DATA;
							n.half = 1'b0;
						end
					end
				end
				LK_DATA: begin
					if (fall) begin
						n.io_oe = QRP_ALL_LINES;
						n.half = !q.half;
						if (!q.half) begin
							n.io_out = q.dbyte[7:4];
						end else begin
							n.io_out = q.dbyte[3:0];
							n.addr = q.addr + 24'h000001;
							n.mem_addr = q.addr + 24'h000001;
							n.rd_pend = 2'h1;
						end
					end
				end
				LK_PADDR: begin
					if (rise) begin
						n.addr = addr_in;
						n.cnt = q.cnt + 6'h01;
						if (q.cnt == addr_last) begin
							n.st = LK_PDATA;
							n.cnt = 6'h00;
							n.col = addr_in[7:0];
						end
					end
				end
				LK_PDATA: begin
					if (rise) begin
						n.sh = sh_in;
						n.cnt = q.cnt + 6'h01;
						if (q.cnt == byte_last) begin
							n.cnt = 6'h00;
							n.pbuf[{q.col, 3'h0} +: 8] = sh_in;
							n.vld[q.col] = 1'b1;
							n.col = q.col + 8'h01;
						end
					end
				end
				LK_STAT: begin
					if (fall) begin
						if (qpi_mode_i) begin
							n.io_oe = QRP_ALL_LINES;
							n.io_out = q.half ? stat_now[3:0] : stat_now[7:4];
							n.half = !q.half;
						end else begin
							n.io_oe = QRP_LINE1;
							n.io_out = {2'h0, stat_now[3'h7 - q.cnt[2:0]], 1'h0};
							n.cnt = {3'h0, q.cnt[2:0] + 3'h1};
						end
					end
				end
				LK_SKIP: begin
					n.io_oe = 4'h0;
				end
				default: begin
					n.st = LK_SKIP;
				end
			endcase
		end

		// Read-modify-write through the FIFO so a stalled memory holds us here
		case (q.pst)
			PG_IDLE: begin
				// Frame end above starts the walk; keep its request
				n.pst = n.write_in_progress ? PG_LOOK : PG_IDLE;
			end
			PG_LOOK: begin
				if (q.vld[q.idx]) begin
					n.mem_addr = {q.addr[QRP_ADDR_W-1:8], q.idx};
					n.pst = PG_READ;
				end else if (q.idx == QRP_LAST_COL) begin
					n.idx = 8'h00;
					n.pst = PG_IDLE;
					n.cr = q.cr;
				end else begin
					n.idx = q.idx + 8'h01;
				end
				if (!q.vld[q.idx] && q.idx == QRP_LAST_COL && !f_out_valid) begin
					n.write_in_progress = 1'b0;
					// A write enable landing in this cycle wins over the clear
					n.write_enable_latch = write_enable_cmd_hit;
				end else if (!q.vld[q.idx] && q.idx == QRP_LAST_COL) begin
					n.pst = PG_LOOK;
				end
			end
			PG_READ: begin
				n.pst = PG_PUSH;
			end
			PG_PUSH: begin
				if (f_in_ready) begin
					n.vld[q.idx] = 1'b0;
					n.pst = PG_LOOK;
				end
			end
			default: begin
				n.pst = PG_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q <= '{st: LK_IDLE, pst: PG_IDLE, cs_prev: 1'b1, default: '0};
		end else begin
			q <= n;
		end
	end

	assign line_o = q.io_out;
	assign line_oe_o = q.io_oe;
	assign mem_addr_o = q.mem_addr;
	assign write_in_progress_o = q.write_in_progress;
	assign write_enable_latch_o = q.write_enable_latch;
	assign continuous_read_mode_o = q.cr;
	assign prog_valid_o = f_out_valid;
	assign prog_addr_o = f_out_data[QRP_FIFO_W-1:8];
	assign prog_data_o = f_out_data[7:0];
endmodule : qrp_flash_seq
`default_nettype wire

// [qrp_flash_seq_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module qrp_flash_seq_checker
	import qrp_pkg::*;
(
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic chip_en_n_i,
	input wire logic qpi_mode_i,
	input wire logic [3:0] line_oe_o,
	input wire logic prog_valid_o,
	input wire logic prog_ready_i,
	input wire logic [QRP_ADDR_W-1:0] prog_addr_o,
	input wire logic [7:0] prog_data_o,
	input wire logic write_in_progress_o,
	input wire logic write_enable_latch_o,
	input wire logic continuous_read_mode_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	a_ce_stop: assert property ($rose(chip_en_n_i) |-> ##[1:8] line_oe_o == 4'h0)
		else $error("lines driven after frame end");
	a_oe_shape: assert property (line_oe_o inside {4'h0, 4'h2, 4'hF})
		else $error("partial output enable");
	a_busy_read: assert property (write_in_progress_o && $past(write_in_progress_o, 8) && !qpi_mode_i
		|-> line_oe_o != 4'hF)
		else $error("read served while busy");
	a_wel_fall: assert property ($fell(write_in_progress_o) |-> !write_enable_latch_o && !prog_valid_o)
		else $error("latch kept after program");
	a_need_wel: assert property ($rose(write_in_progress_o) |-> $past(write_enable_latch_o))
		else $error("program without latch");
	a_start_ce: assert property ($rose(write_in_progress_o) |-> chip_en_n_i)
		else $error("program started inside frame");
	a_prog_busy: assert property (prog_valid_o |-> write_in_progress_o)
		else $error("array write while idle");
	a_prog_hold: assert property (prog_valid_o && !prog_ready_i
		|=> prog_valid_o && $stable(prog_addr_o) && $stable(prog_data_o))
		else $error("write dropped while stalled");
	a_same_page: assert property (prog_valid_o ##1 prog_valid_o
		|-> (prog_addr_o ^ $past(prog_addr_o)) < 24'h000100)
		else $error("program left its page");
	a_cont_set: assert property ($rose(continuous_read_mode_o) |-> !chip_en_n_i)
		else $error("continuous mode set outside frame");
	cover property ($rose(continuous_read_mode_o));
	cover property (prog_valid_o && !prog_ready_i);
	cover property ($fell(write_in_progress_o));
endmodule : qrp_flash_seq_checker
bind qrp_flash_seq qrp_flash_seq_checker u_qrp_flash_seq_checker (.mclk_i(mclk_i), .resetn_i(resetn_i),
	.chip_en_n_i(chip_en_n_i), .qpi_mode_i(qpi_mode_i), .line_oe_o(line_oe_o),
	.prog_valid_o(prog_valid_o), .prog_ready_i(prog_ready_i), .prog_addr_o(prog_addr_o),
	.prog_data_o(prog_data_o), .write_in_progress_o(write_in_progress_o),
	.write_enable_latch_o(write_enable_latch_o), .continuous_read_mode_o(continuous_read_mode_o));
`default_nettype wire

// [qrp_flash_seq_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module qrp_flash_seq_tb;
	import qrp_pkg::*;
	logic mclk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic sck = 1'b0;
	logic ce_n = 1'b1;
	logic qpi = 1'b0;
	logic stall = 1'b0;
	logic [3:0] prot = 4'h0;
	logic [3:0] hv = 4'h0;
	logic [3:0] lo, oe;
	logic [23:0] ma, pa;
	logic [7:0] rd, pd;
	logic pv, pr, write_in_progress, write_enable_latch, cont;
	logic [7:0] sh [4096];
	logic [7:0] last [256];
	int error_cnt = 0;
	int total_checks = 0;
	wire logic [3:0] lines = (oe & lo) | (~oe & hv);
	always #2.5 mclk_i = ~mclk_i;
	qrp_flash_seq u_qrp_flash_seq (.mclk_i(mclk_i), .resetn_i(resetn_i), .sck_i(sck), .chip_en_n_i(ce_n),
		.line_i(lines), .line_o(lo), .line_oe_o(oe), .qpi_mode_i(qpi), .protect_bits_i(prot),
		.mem_addr_o(ma), .mem_rdata_i(rd), .prog_valid_o(pv), .prog_ready_i(pr), .prog_addr_o(pa),
		.prog_data_o(pd), .write_in_progress_o(write_in_progress), .write_enable_latch_o(write_enable_latch),
		.continuous_read_mode_o(cont));
	qrp_mem_model u_qrp_mem_model (.mclk_i(mclk_i), .stall_i(stall), .addr_i(ma), .rdata_o(rd),
		.wr_valid_i(pv), .wr_ready_o(pr), .wr_addr_i(pa), .wr_data_i(pd));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	// Host changes lines on the fall, device samples on the rise
	task automatic cyc(input logic [3:0] v);
		sck <= 1'b0;
		hv <= v;
		#24 sck <= 1'b1;
		#24;
	endtask : cyc
	task automatic tx(input logic [7:0] b);
		if (qpi) begin
			cyc(b[7:4]);
			cyc(b[3:0]);
		end else
			for (int i = 7; i >= 0; i--) cyc({3'b000, b[i]});
	endtask : tx
	task automatic go;
		ce_n <= 1'b0;
		#20;
	endtask : go
	task automatic stop;
		sck <= 1'b0;
		#24 ce_n <= 1'b1;
		repeat (10) @(posedge mclk_i);
		chk({4'h0, oe}, 8'h00);
	endtask : stop
	task automatic rq(input logic op, input logic [23:0] a, input logic [7:0] md, input int n, input logic ign);
		logic [23:0] x;
		x = a;
		go();
		if (op)
			tx(QRP_OP_QREAD);
		for (int i = 5; i >= 0; i--) cyc(a[i*4 +: 4]);
		cyc(md[7:4]);
		cyc(md[3:0]);
		repeat (4) cyc(4'h0);
		// Released lines toggle so a stale value cannot pass
		for (int k = 0; k < n; k++) begin
			cyc(~hv);
			chk({oe, lo & oe}, ign ? 8'h00 : {4'hF, sh[x[11:0]][7:4]});
			cyc(~hv);
			chk({oe, lo & oe}, ign ? 8'h00 : {4'hF, sh[x[11:0]][3:0]});
			x++;
		end
		stop();
	endtask : rq
	task automatic rs(input logic [7:0] e);
		logic [7:0] g;
		go();
		tx(QRP_OP_STATUS_READ_CMD);
		if (qpi) begin
			cyc(~hv);
			g[7:4] = lo & oe;
			cyc(~hv);
			g[3:0] = lo & oe;
		end else
			for (int i = 7; i >= 0; i--) begin
				cyc(~hv);
				g[i] = lo[1] & oe[1];
			end
		chk(g, e);
		stop();
	endtask : rs
	task automatic write_enable_cmd;
		go();
		tx(QRP_OP_WRITE_ENABLE_CMD);
		stop();
		chk({7'h0, write_enable_latch}, 8'h01);
	endtask : write_enable_cmd
	task automatic pp(input logic [23:0] a, input int n, input logic [7:0] s, input logic ok);
		go();
		tx(QRP_OP_PROG);
		for (int i = 2; i >= 0; i--) tx(a[i*8 +: 8]);
		for (int k = 0; k < n; k++) tx(s ^ k[7:0] ^ k[15:8]);
		stop();
		chk({7'h0, write_in_progress}, {7'h0, ok});
		for (int k = 0; k < 256; k++) last[k] = 8'hFF;
		for (int k = 0; k < n; k++) last[8'(a[7:0] + k[7:0])] = s ^ k[7:0] ^ k[15:8];
		for (int k = 0; k < 256; k++) if (ok) sh[{a[11:8], k[7:0]}] &= last[k];
	endtask : pp
	task automatic drain;
		for (int i = 0; i < 9000 && write_in_progress !== 1'b0; i++) @(posedge mclk_i);
		chk({6'h0, write_in_progress, write_enable_latch}, 8'h00);
	endtask : drain
	initial begin
		for (int i = 0; i < 4096; i++) sh[i] = i[7:0] ^ 8'h5A;
		repeat (16) @(posedge mclk_i);
		resetn_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		chk({5'h0, cont, write_in_progress, write_enable_latch}, 8'h00);
		rq(1'b1, 24'hFFFFFE, 8'h00, 3, 1'b0);
		rq(1'b1, 24'h000123, 8'hA5, 2, 1'b0);
		chk({7'h0, cont}, 8'h01);
		rq(1'b0, 24'h000456, 8'h50, 2, 1'b0);
		chk({7'h0, cont}, 8'h00);
		qpi <= 1'b1;
		rq(1'b1, 24'h000789, 8'hAF, 1, 1'b0);
		rq(1'b0, 24'h000A00, 8'h00, 1, 1'b0);
		qpi <= 1'b0;
		pp(24'h0002FF, 2, 8'h0F, 1'b0);
		write_enable_cmd();
		prot <= 4'h1;
		pp(24'hF00010, 1, 8'h00, 1'b0);
		prot <= 4'h0;
		write_enable_cmd();
		pp(24'h0002FF, 2, 8'h0F, 1'b1);
		drain();
		qpi <= 1'b1;
		write_enable_cmd();
		pp(24'h000200, 258, 8'hC3, 1'b1);
		rs(8'h03);
		drain();
		qpi <= 1'b0;
		write_enable_cmd();
		stall <= 1'b1;
		pp(24'h000300, 4, 8'h33, 1'b1);
		rs(8'h03);
		rq(1'b1, 24'h000300, 8'h00, 1, 1'b1);
		stall <= 1'b0;
		drain();
		rs(8'h00);
		rq(1'b1, 24'h0002FD, 8'h00, 9, 1'b0);
		close_out();
	end
	initial begin
		#500000;
		error_cnt++;
		close_out();
	end
endmodule : qrp_flash_seq_tb
`default_nettype wire

// [qrp_mem_model.sv]
`timescale 1ns/10ps
`default_nettype none
module qrp_mem_model (
	input wire logic mclk_i,
	input wire logic stall_i,
	input wire logic [23:0] addr_i,
	output logic [7:0] rdata_o,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	input wire logic [23:0] wr_addr_i,
	input wire logic [7:0] wr_data_i
);
	logic [7:0] m [4096];
	logic slow_q = 1'b0;
	// Small image, upper address bits alias
	initial for (int i = 0; i < 4096; i++) m[i] = i[7:0] ^ 8'h5A;
	// Accepts every other cycle, never while stalled
	assign wr_ready_o = !stall_i && slow_q;
	always @(posedge mclk_i) begin
		slow_q <= !slow_q;
		rdata_o <= m[addr_i[11:0]];
		if (wr_valid_i && wr_ready_o)
			m[wr_addr_i[11:0]] <= wr_data_i;
	end
endmodule : qrp_mem_model
`default_nettype wire

// [qrp_pkg.sv]
package qrp_pkg;
	localparam logic [7:0] QRP_OP_QREAD = 8'hEB;
	localparam logic [7:0] QRP_OP_PROG = 8'h02;
	localparam logic [7:0] QRP_OP_WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] QRP_OP_STATUS_READ_CMD = 8'h05;
	localparam logic [3:0] QRP_CONT_NIB = 4'hA;
	localparam logic [5:0] QRP_DUMMY_CYC = 6'h06;
	localparam logic [5:0] QRP_BYTE_BITS = 6'h08;
	localparam logic [5:0] QRP_BYTE_NIBS = 6'h02;
	localparam logic [5:0] QRP_ADDR_BITS = 6'h18;
	localparam logic [5:0] QRP_ADDR_NIBS = 6'h06;
	localparam int QRP_ADDR_W = 24;
	localparam int QRP_WIP_BIT = 0;
	localparam int QRP_WEL_BIT = 1;
	localparam int QRP_PAGE_BYTES = 256;
	localparam logic [7:0] QRP_LAST_COL = 8'hFF;
	localparam logic [4:0] QRP_PROT_REGIONS = 5'h10;
	localparam int QRP_FIFO_DEPTH = 4;
	localparam int QRP_FIFO_W = 32;
	localparam logic [3:0] QRP_ALL_LINES = 4'hF;
	localparam logic [3:0] QRP_LINE1 = 4'h2;

	typedef enum logic [8:0] {
		LK_IDLE = 9'h001,
		LK_CMD = 9'h002,
		LK_ADDR = 9'h004,
		LK_DUMMY = 9'h008,
		LK_DATA = 9'h010,
		LK_PADDR = 9'h020,
		LK_PDATA = 9'h040,
		LK_STAT = 9'h080,
		LK_SKIP = 9'h100
	} qrp_link_e;

	typedef enum logic [3:0] {
		PG_IDLE = 4'h1,
		PG_LOOK = 4'h2,
		PG_READ = 4'h4,
		PG_PUSH = 4'h8
	} qrp_prog_e;
endpackage : qrp_pkg

// [qrp_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module qrp_sync #(
	parameter int W = 6,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} qrp_sync_s;

	qrp_sync_s q, n;

	always_comb begin
		n = q;
		n.s1 = d_i;
		n.s2 = q.s1;
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q <= '{s1: RST, s2: RST};
		end else begin
			q <= n;
		end
	end

	assign q_o = q.s2;
endmodule : qrp_sync
`default_nettype wire
